// [sfb_front_end.v]
// Serial flash bus front end: select, shift, hold, status-write gating
`timescale 1ns/10ps
`default_nettype none
`include "sfb_map.vh"
module sfb_front_end #(
  parameter [7:0] STATUS_WRITE_CMD = 8'h01
) (
  input wire sys_clk,
  input wire nrst,
  input wire ce,
  input wire sck_pin,
  input wire cs_n_pin,
  input wire si_pin,
  input wire hold_n_pin,
  input wire wp_n_pin,
  output reg so_out,
  output reg so_oe,
  input wire tx_drive,
  input wire [7:0] tx_data,
  input wire auto_increment_program,
  input wire busy_in,
  input wire wel_in,
  input wire [23:0] erase_addr,
  input wire [1:0] erase_size,
  output reg [7:0] rx_byte,
  output reg rx_valid,
  output reg selected,
  output reg paused,
  output reg status_write_done,
  output reg status_write_reject,
  output reg [7:0] status_out,
  output reg [23:0] erase_base
);
  wire [4:0] pins_s;
  wire sck_s;
  wire cs_n_s;
  wire si_s;
  wire hold_n_s;
  wire wp_n_s;
  reg sck_d_reg;
  reg cs_n_d_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] rx_shift_reg;
  reg [7:0] tx_shift_reg;
  reg [1:0] byte_idx_reg;
  reg is_wr_cmd_reg;
  reg [7:0] wr_data_reg;
  reg [3:0] protect_level_reg;
  reg protect_lock_bit;
  wire sck_rise;
  wire sck_fall;
  wire cs_fall;
  wire cs_rise;
  wire active;
  wire [7:0] rx_word;
  wire wr_allowed;
  wire wr_complete;
  reg [23:0] granule;

  // Pins cross into the system clock domain; idle levels deselected
  sfb_sync #(
    .WIDTH(5),
    .RST_VAL(5'h1a)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .ce(ce),
    .async_in({hold_n_pin, cs_n_pin, wp_n_pin, sck_pin, si_pin}),
    .sync_out(pins_s)
  );
  assign si_s = pins_s[0];
  assign sck_s = pins_s[1];
  assign wp_n_s = pins_s[2];
  assign cs_n_s = pins_s[3];
  assign hold_n_s = pins_s[4];

  // Edge detection; either idle clock level works since only edges count
  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;
  assign cs_fall = ~cs_n_s & cs_n_d_reg;
  assign cs_rise = cs_n_s & ~cs_n_d_reg;
  assign active = selected & ~paused & ~cs_n_s;
  assign rx_word = {rx_shift_reg[6:0], si_s};

  // Status write gate and completion on a clean byte boundary
  assign wr_allowed = wp_n_s | ~protect_lock_bit;
  assign wr_complete = cs_rise & selected & ~paused & is_wr_cmd_reg &
    (byte_idx_reg == 2'h2) & (bit_cnt_reg == 3'h0);

  // Edge history registers
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sck_d_reg <= 1'b1; // Same as synchroniser reset: no false edge
      cs_n_d_reg <= 1'b1;
    end
    else if (ce)
    begin
      sck_d_reg <= sck_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  // Select, pause and receive shifting
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      selected <= 1'b0;
      paused <= 1'b0;
      bit_cnt_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      is_wr_cmd_reg <= 1'b0;
      wr_data_reg <= 8'h00;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end
    else if (ce)
    begin
      rx_valid <= 1'b0;
      if (cs_n_s)
      begin
        // Deselect ends everything, paused or not
        selected <= 1'b0;
        paused <= 1'b0;
        bit_cnt_reg <= 3'h0;
        byte_idx_reg <= 2'h0;
        is_wr_cmd_reg <= 1'b0;
      end
      else if (cs_fall)
      begin
        selected <= 1'b1;
        paused <= 1'b0;
        bit_cnt_reg <= 3'h0;
        byte_idx_reg <= 2'h0;
        is_wr_cmd_reg <= 1'b0;
      end
      else if (selected)
      begin
        // Hold changes take effect only while the clock is low
        if (!sck_s)
        begin
          paused <= ~hold_n_s;
        end
        if (active && sck_rise)
        begin
          // Position counters untouched while paused
          rx_shift_reg <= rx_word;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7)
          begin
            rx_byte <= rx_word;
            rx_valid <= 1'b1;
            if (byte_idx_reg == 2'h0)
            begin
              is_wr_cmd_reg <= (rx_word == STATUS_WRITE_CMD);
            end
            if (byte_idx_reg == 2'h1)
            begin
              wr_data_reg <= rx_word;
            end
            if (byte_idx_reg != 2'h3)
            begin
              byte_idx_reg <= byte_idx_reg + 2'h1;
            end
          end
        end
      end
    end
  end

  // Protection bits; lock clears at power-up
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      protect_level_reg <= `SFB_BP_RESET;
      protect_lock_bit <= `SFB_LOCK_RESET;
      status_write_done <= 1'b0;
      status_write_reject <= 1'b0;
    end
    else if (ce)
    begin
      status_write_done <= 1'b0;
      status_write_reject <= 1'b0;
      if (wr_complete && wel_in)
      begin
        if (wr_allowed)
        begin
          protect_level_reg <= wr_data_reg[`SFB_ST_BP3:`SFB_ST_BP0];
          protect_lock_bit <= wr_data_reg[`SFB_ST_LOCK];
          status_write_done <= 1'b1;
        end
        else
        begin
          status_write_reject <= 1'b1;
        end
      end
    end
  end

  // Serial output: falling-edge shift, busy readout, float when idle
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_shift_reg <= 8'h00;
      so_out <= 1'b0;
      so_oe <= 1'b0;
    end
    else if (ce)
    begin
      // Float also from the very cycle a pause starts
      if (!active || (!sck_s && !hold_n_s))
      begin
        so_oe <= 1'b0;
      end
      else if (auto_increment_program)
      begin
        so_oe <= 1'b1;
        so_out <= ~busy_in;
      end
      else
      begin
        so_oe <= tx_drive;
        if (sck_fall)
        begin
          if (bit_cnt_reg == 3'h0)
          begin
            so_out <= tx_data[7];
            tx_shift_reg <= {tx_data[6:0], 1'b0};
          end
          else
          begin
            so_out <= tx_shift_reg[7];
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Erase granule selection
  always @*
  begin
    case (erase_size)
      `SFB_ERASE_SECTOR: granule = `SFB_SECTOR_BYTES;
      `SFB_ERASE_BLK32: granule = `SFB_BLOCK32_BYTES;
      `SFB_ERASE_BLK64: granule = `SFB_BLOCK64_BYTES;
      default: granule = `SFB_SECTOR_BYTES;
    endcase
  end

  // Status image and aligned erase base
  always @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_out <= `SFB_STATUS_RESET;
      erase_base <= 24'h000000;
    end
    else if (ce)
    begin
      status_out <= {protect_lock_bit, auto_increment_program,
        protect_level_reg, wel_in, busy_in};
      erase_base <= erase_addr & ~(granule - 24'h000001);
    end
  end
endmodule
`default_nettype wire

// [sfb_front_end_chk.sv]
// Port assertions for the serial flash bus front end
`timescale 1ns/10ps
`default_nettype none
module sfb_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic cs_n_pin,
  input wire logic hold_n_pin,
  input wire logic so_oe,
  input wire logic rx_valid,
  input wire logic selected,
  input wire logic paused,
  input wire logic status_write_done,
  input wire logic status_write_reject,
  input wire logic [7:0] status_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Output driven only while selected and running
  a_oe_live: assert property (
    so_oe |-> selected && !paused) else $error("output on while idle");
  // High select drops the selection
  a_desel_high: assert property (
    cs_n_pin [*5] |-> !selected) else $error("selected, select high");
  // Selection starts only from a low select pin
  a_sel_start: assert property (
    $rose(selected) |-> !$past(cs_n_pin, 2)) else $error("select too early");
  // Hold kept low keeps the pause
  a_pause_keep: assert property (
    (!hold_n_pin && !cs_n_pin) [*4] ##0 paused |=> paused)
    else $error("pause left while hold low");
  // Byte flag is a single pulse
  a_rx_single: assert property (
    rx_valid |=> !rx_valid) else $error("byte flag too long");
  // Refusal only with the lock bit set
  a_rej_lock: assert property (
    status_write_reject |-> status_out[7]) else $error("refused, unlocked");
  // Refusal leaves lock and protection bits alone
  a_rej_keep: assert property (
    status_write_reject |=> $stable({status_out[7], status_out[5:2]}) [*2])
    else $error("locked bits changed");
  // Status write completes only at deselection
  a_done_desel: assert property (
    status_write_done |-> !selected) else $error("done while selected");
  // Main scenarios reached
  cover property (status_write_done);
  cover property (status_write_reject);
  cover property (paused);
endmodule
bind sfb_front_end sfb_chk u_chk (.sys_clk, .nrst, .cs_n_pin, .hold_n_pin,
  .so_oe, .rx_valid, .selected, .paused, .status_write_done,
  .status_write_reject, .status_out);
`default_nettype wire

// [sfb_host.sv]
// Serial bus host model driving the flash front end pins
`timescale 1ns/10ps
`default_nettype none
module sfb_host (
  output logic sck,
  output logic cs_n,
  output logic si,
  output logic hold_n,
  input wire logic so
);
  logic idle;
  // Pins idle, device deselected
  initial
  begin
    idle = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  // Clock idle level: low for mode 0, high for mode 3
  task automatic mode(input logic m);
    idle = m;
    #62.5 sck = m;
    #62.5;
  endtask
  // Select; stays low through the whole sequence
  task automatic sel();
    #62.5 cs_n = 1'b0;
    #62.5;
  endtask
  // Shift n bits MSB first, data set on fall, output taken on rise
  task automatic bits(input logic [7:0] d, input int n,
    output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sck = 1'b0;
      si = d[i];
      #62.5 sck = 1'b1;
      q[i] = so;
      #62.5;
    end
  endtask
  // Hold changed at clock low; clock and data wiggle while held
  task automatic pause(input logic h);
    sck = 1'b0;
    #62.5 hold_n = h;
    repeat (h ? 0 : 4)
    begin
      #62.5 sck = ~sck;
      si = ~si;
    end
    #125;
  endtask
  // Deselect; released data line shows no stale level
  task automatic desel();
    sck = idle;
    #62.5 cs_n = 1'b1;
    si = ~si;
    #62.5;
  endtask
endmodule
`default_nettype wire

// [sfb_map.vh]
// Constants for the serial flash bus front end
`ifndef SFB_MAP_VH
`define SFB_MAP_VH
// Status register field positions
`define SFB_ST_BUSY 0
`define SFB_ST_WEL 1
`define SFB_ST_BP0 2
`define SFB_ST_BP3 5
`define SFB_ST_AAI 6
`define SFB_ST_LOCK 7
// Power-up values of the protection fields
`define SFB_BP_RESET 4'h7
`define SFB_LOCK_RESET 1'b0
// Power-up status image: protection level 0111, all else clear
`define SFB_STATUS_RESET 8'h1c
// Bus cycle length in bits
`define SFB_BITS_PER_CYCLE 4'h8
// Erase granule sizes in bytes
`define SFB_SECTOR_BYTES 24'h001000
`define SFB_BLOCK32_BYTES 24'h008000
`define SFB_BLOCK64_BYTES 24'h010000
// Erase size selectors
`define SFB_ERASE_SECTOR 2'h0
`define SFB_ERASE_BLK32 2'h1
`define SFB_ERASE_BLK64 2'h2
`endif

// [sfb_sync.v]
// Two-flop synchroniser bank for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module sfb_sync #(
  parameter WIDTH = 5,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire sys_clk,
  input wire nrst,
  input wire ce,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  genvar i;
  // One two-stage chain per bit; first stage feeds only the second
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg meta_reg;
      reg sync_reg;
      always @(posedge sys_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_reg <= RST_VAL[i];
          sync_reg <= RST_VAL[i];
        end
        else if (ce)
        begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
        end
      end
      assign sync_out[i] = sync_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the serial flash bus front end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic sys_clk, nrst, tx_drive, busy_in, wel_in, wp_n_pin, so_out, so_oe;
  logic sck_pin, cs_n_pin, si_pin, hold_n_pin, rx_valid, selected, paused;
  logic auto_increment_program, status_write_done, status_write_reject;
  logic [7:0] tx_data, q, rx_byte, status_out;
  logic ce;
  logic [23:0] erase_addr, erase_base;
  logic [1:0] erase_size;
  logic [23:0] eb [4] = '{24'h012000, 24'h010000, 24'h010000, 24'h012000};
  wire logic so = so_oe ? so_out : 1'bz;
  int mismatches = 0, comparisons = 0, nd = 0, nr = 0;
  sfb_front_end DUT (.sys_clk, .nrst, .ce, .sck_pin, .cs_n_pin,
    .si_pin, .hold_n_pin, .wp_n_pin, .so_out, .so_oe, .tx_drive, .tx_data,
    .auto_increment_program, .busy_in, .wel_in, .erase_addr, .erase_size,
    .rx_byte, .rx_valid, .selected, .paused, .status_write_done,
    .status_write_reject, .status_out, .erase_base);
  sfb_host u (.sck(sck_pin), .cs_n(cs_n_pin), .si(si_pin),
    .hold_n(hold_n_pin), .so(so));
  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // Count completion and refusal pulses
  always @(posedge sys_clk)
  begin
    nd += (status_write_done === 1'b1);
    nr += (status_write_reject === 1'b1);
  end
  // Compare and report
  task automatic chk(input string s, input logic [23:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Full status write: opcode then one data byte
  task automatic wr(input logic [7:0] d);
    u.sel();
    u.bits(8'h01, 8, q);
    u.bits(d, 8, q);
    u.desel();
  endtask
  // Input change just after a clock edge
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  // Overall bound on the run
  initial
  begin
    #200us;
    mismatches++;
    test_done();
  end
  initial
  begin
    nrst = 1'b0;
    {tx_drive, auto_increment_program, busy_in, wp_n_pin} = 4'h0;
    wel_in = 1'b1;
    ce = 1'b1;
    tx_data = 8'h96;
    erase_addr = 24'h012345;
    erase_size = 2'h0;
    repeat (10) tick();
    nrst = 1'b1;
    chk("status", 8'h1c, status_out);
    for (int s = 0; s < 4; s++)
    begin
      erase_size = s[1:0];
      repeat (3) tick();
      chk("erase", eb[s], erase_base);
    end
    erase_addr = 24'h07ffff;
    repeat (3) tick();
    chk("erase top", 24'h07f000, erase_base);
    wr(8'h9c);
    chk("rx", 8'h9c, rx_byte);
    chk("lock", 5'h17, {status_out[7], status_out[5:2]});
    u.mode(1'b1);
    wr(8'h00);
    chk("refused", 2'h3, {nd == 1, nr == 1});
    chk("kept", 5'h17, {status_out[7], status_out[5:2]});
    tick();
    wp_n_pin = 1'b1;
    wr(8'h00);
    chk("open", 3'h6, {nd == 2, nr == 1, status_out[7]});
    chk("level", 4'h0, status_out[5:2]);
    tick();
    wel_in = 1'b0;
    wr(8'h80);
    chk("no wel", 2'h2, {nd == 2, status_out[7]});
    tick();
    wel_in = 1'b1;
    u.sel();
    u.bits(8'h01, 8, q);
    u.bits(8'h00, 5, q);
    u.desel();
    chk("abort", 2'h2, {nd[1:0]} ^ {1'b0, nr == 2});
    tick();
    tx_drive = 1'b1;
    u.sel();
    u.bits(8'ha5, 4, q);
    u.pause(1'b0);
    chk("held", 2'h2, {paused, so_oe});
    u.pause(1'b1);
    chk("resume", 1'b0, paused);
    u.bits(8'h50, 4, q);
    chk("kept bits", 8'ha5, rx_byte);
    u.bits(8'hff, 3, q);
    u.pause(1'b0);
    u.desel();
    chk("reset", 2'h0, {paused, selected});
    u.pause(1'b1);
    u.sel();
    u.bits(8'h3c, 8, q);
    chk("fresh", 8'h3c, rx_byte);
    u.desel();
    tick();
    tx_drive = 1'b1;
    u.sel();
    u.bits(8'h03, 8, q);
    u.bits(8'h00, 8, q);
    chk("read", 8'h96, q);
    u.desel();
    tick();
    {tx_drive, auto_increment_program, busy_in} = 3'h3;
    u.sel();
    chk("busy", 2'h2, {so_oe, so_out});
    tick();
    busy_in = 1'b0;
    repeat (6) tick();
    chk("ready", 2'h3, {so_oe, so_out});
    ce = 1'b0;
    busy_in = 1'b1;
    repeat (4) tick();
    chk("frozen", 2'h3, {so_oe, so_out});
    ce = 1'b1;
    tick();
    u.desel();
    chk("float", 1'b0, so_oe);
    test_done();
  end
endmodule
`default_nettype wire
